// ===== dtr_pkg_counter.sv
`timescale 1ns/10ps
// ****************************************************************
// shared constants and types
// ****************************************************************
package dtr_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned TRIG_CLK_HZ = 2_000_000;
    localparam int unsigned PRESCALE = CLK_HZ / TRIG_CLK_HZ;
    localparam int PRESCALE_W = 3;
    localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = 3'(PRESCALE - 1);
    localparam int CNT0_W = 16;
    localparam int TRIG_HALF_W = 16;
    localparam int CODE_W = 12;
    localparam int CHAN_W = 3;
    localparam logic [CODE_W-1:0] CODE_ZERO = 12'h000;
    localparam logic [CODE_W-1:0] CODE_MID = 12'h800;
    localparam logic [CODE_W-1:0] CODE_FULL = 12'hfff;
    localparam logic CNT0_OUT_RESET = 1'b1;

    typedef struct packed {
        logic [CHAN_W-1:0] addr;
        logic [CODE_W-1:0] data;
    } dtr_dac_bus_type;
endpackage

// ****************************************************************
// reloading down-counter, terminal count on the tick taken while the count is one or zero
// ****************************************************************
module dtr_down_counter #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // control
    input wire logic i_run,
    input wire logic i_tick,
    input wire logic [WIDTH-1:0] i_reload,
    // status
    output logic [WIDTH-1:0] o_count,
    output logic o_tc
);
    logic [WIDTH-1:0] count_q;

    // a reload of zero or one behaves as divide-by-one
    assign o_tc = i_run && i_tick && (count_q <= WIDTH'(1));
    assign o_count = count_q;

    always_ff @(posedge i_clock) begin
        if (i_rst || !i_run) begin
            count_q <= i_reload;
        end else if (o_tc) begin
            count_q <= i_reload;
        end else if (i_tick) begin
            count_q <= count_q - WIDTH'(1);
        end
    end
endmodule

// ===== dtr_timers.sv
`timescale 1ns/10ps
module dtr_timers (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // host control levels
    input wire logic i_ref_enable,
    input wire logic i_cnt0_run,
    input wire logic [dtr_pkg::CNT0_W-1:0] i_cnt0_reload,
    input wire logic i_trig_run,
    input wire logic [dtr_pkg::TRIG_HALF_W-1:0] i_trig_reload_lo,
    input wire logic [dtr_pkg::TRIG_HALF_W-1:0] i_trig_reload_hi,
    input wire logic i_irq_en_cnt0,
    input wire logic i_irq_en_conv,
    input wire logic i_irq_clear,
    // channel code write
    input wire logic i_wr_valid,
    input wire dtr_pkg::dtr_dac_bus_type i_wr,
    // converter port
    output dtr_pkg::dtr_dac_bus_type o_dac_bus,
    output logic o_dac_load,
    output logic o_dac_start,
    output logic o_dac_zero,
    output logic o_ref_on,
    // counter pin and interrupt
    output logic o_cnt0_out,
    output logic o_irq
);
    // ****************************************************************
    // 2 MHz tick for the trigger chain
    // ****************************************************************
    logic [dtr_pkg::PRESCALE_W-1:0] presc_q;
    logic tick2m;

    assign tick2m = (presc_q == dtr_pkg::PRESCALE_LAST);

    always_ff @(posedge i_clock) begin
        if (i_rst || tick2m) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_q + dtr_pkg::PRESCALE_W'(1);
        end
    end

    // ****************************************************************
    // counters
    // ****************************************************************
    logic tc0;
    logic tc1;
    logic tc2;

    dtr_down_counter #(.WIDTH(dtr_pkg::CNT0_W)) u_cnt0 (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_run(i_cnt0_run),
        .i_tick(1'b1),
        .i_reload(i_cnt0_reload),
        .o_count(),
        .o_tc(tc0)
    );

    dtr_down_counter #(.WIDTH(dtr_pkg::TRIG_HALF_W)) u_cnt1 (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_run(i_trig_run),
        .i_tick(tick2m),
        .i_reload(i_trig_reload_lo),
        .o_count(),
        .o_tc(tc1)
    );

    // low half's terminal count clocks the high half
    dtr_down_counter #(.WIDTH(dtr_pkg::TRIG_HALF_W)) u_cnt2 (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_run(i_trig_run),
        .i_tick(tc1),
        .i_reload(i_trig_reload_hi),
        .o_count(),
        .o_tc(tc2)
    );

    // square wave on the pin: toggles at each terminal count
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_cnt0_out <= dtr_pkg::CNT0_OUT_RESET;
        end else if (tc0) begin
            o_cnt0_out <= ~o_cnt0_out;
        end
    end

    // ****************************************************************
    // conversion start
    // ****************************************************************
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_dac_start <= 1'b0;
        end else begin
            o_dac_start <= tc2;
        end
    end

    // ****************************************************************
    // interrupt: sticky, set wins over clear
    // ****************************************************************
    logic cnt0_fall;

    assign cnt0_fall = tc0 && o_cnt0_out;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else if ((cnt0_fall && i_irq_en_cnt0) || (tc2 && i_irq_en_conv)) begin
            o_irq <= 1'b1;
        end else if (i_irq_clear) begin
            o_irq <= 1'b0;
        end
    end

    // ****************************************************************
    // reference and channel codes
    // ****************************************************************
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_ref_on <= 1'b0;
            o_dac_zero <= 1'b1;
        end else begin
            o_ref_on <= i_ref_enable;
            o_dac_zero <= ~i_ref_enable;
        end
    end

    // codes pass untouched while i_ref_enable is high, CODE_ZERO otherwise: offset binary, same code feeds voltage and sink
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_dac_bus <= '0;
            o_dac_load <= 1'b0;
        end else begin
            o_dac_load <= i_wr_valid;
            if (i_wr_valid) begin
                o_dac_bus.addr <= i_wr.addr;
                o_dac_bus.data <= i_ref_enable ? i_wr.data : dtr_pkg::CODE_ZERO;
            end
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    chk_presc_period: assert property (@(posedge i_clock) disable iff (i_rst)
        tick2m |=> !tick2m [*4] ##1 tick2m)
        else $error("trigger tick period is not five clocks");

    chk_chain_tick: assert property (@(posedge i_clock) disable iff (i_rst)
        tc2 |-> tc1 && tick2m)
        else $error("high half counted without low half terminal count");

    chk_start_pulse: assert property (@(posedge i_clock) disable iff (i_rst)
        tc2 |=> o_dac_start ##1 !o_dac_start)
        else $error("start is not a single pulse after terminal count");

    chk_pin_toggle: assert property (@(posedge i_clock) disable iff (i_rst)
        tc0 |=> o_cnt0_out != $past(o_cnt0_out))
        else $error("counter pin did not toggle at terminal count");

    chk_irq_fall: assert property (@(posedge i_clock) disable iff (i_rst)
        (o_cnt0_out && tc0 && i_irq_en_cnt0) |=> o_irq && !o_cnt0_out)
        else $error("falling counter edge did not raise interrupt");

    chk_irq_conv: assert property (@(posedge i_clock) disable iff (i_rst)
        (tc2 && i_irq_en_conv) |=> o_irq && o_dac_start)
        else $error("conversion event did not raise interrupt");

    chk_irq_sticky: assert property (@(posedge i_clock) disable iff (i_rst)
        (o_irq && !i_irq_clear) |=> o_irq)
        else $error("interrupt dropped without a clear");

    chk_ref_reset: assert property (@(posedge i_clock)
        $past(i_rst) |-> !o_ref_on && o_dac_zero)
        else $error("reference not in standby after reset");

    chk_ref_zero: assert property (@(posedge i_clock) disable iff (i_rst)
        (!i_ref_enable && i_wr_valid) |=> o_dac_zero && o_dac_load
            && o_dac_bus.data == dtr_pkg::CODE_ZERO)
        else $error("output not forced to zero with reference off");

    chk_code_pass: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_ref_enable && i_wr_valid) |=> o_dac_load && o_dac_bus == $past(i_wr))
        else $error("channel code or address not passed to converter port");

    chk_load_pulse: assert property (@(posedge i_clock) disable iff (i_rst)
        o_dac_load |-> $past(i_wr_valid))
        else $error("load pulse without a channel write");

    chk_pin_hold: assert property (@(posedge i_clock) disable iff (i_rst)
        !tc0 |=> $stable(o_cnt0_out))
        else $error("counter pin moved without terminal count");

    chk_ref_off: assert property (@(posedge i_clock) disable iff (i_rst)
        !i_ref_enable |=> o_dac_zero && !o_ref_on)
        else $error("outputs not forced to zero with reference disabled");

    chk_start_source: assert property (@(posedge i_clock) disable iff (i_rst)
        o_dac_start |-> $past(tc2))
        else $error("start pulse without a trigger terminal count");

    // set wins, so only a clear with no event in the same cycle may drop the line
    chk_irq_clear: assert property (@(posedge i_clock) disable iff (i_rst)
        (o_irq && i_irq_clear && !(cnt0_fall && i_irq_en_cnt0) && !(tc2 && i_irq_en_conv))
            |=> !o_irq)
        else $error("interrupt not dropped by a clear with no pending event");
endmodule

// ===== dtr_conv_model.sv
`timescale 1ns/10ps
// ****************************************************************
// converter on the far side of the shared port
// ****************************************************************
// codes wait in holding latches until the common start, so one
// channel's load never moves another channel's output early
module dtr_conv_model (
    // clock
    input wire logic i_clock,
    // converter port
    input wire dtr_pkg::dtr_dac_bus_type i_bus,
    input wire logic i_load,
    input wire logic i_start,
    input wire logic i_zero,
    // one code per channel drives both the voltage and the sink output
    output logic [7:0][11:0] o_level
);
    logic [7:0][11:0] held_q;
    always_ff @(posedge i_clock) begin
        if (i_load) begin
            held_q[i_bus.addr] <= i_bus.data;
        end
    end
    always_ff @(posedge i_clock) begin
        if (i_zero) begin
            o_level <= '0;
        end else if (i_start) begin
            o_level <= held_q;
        end
    end
endmodule

// ===== tb_dac_trigger_timers_and_ref_enable.sv
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
// ****************************************************************
// bench
// ****************************************************************
module tb_dac_trigger_timers_and_ref_enable;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic ref_en = 1'b0, c0_run = 1'b0, tr_run = 1'b0, en_c0 = 1'b0, en_cv = 1'b0;
    logic clr = 1'b0, wr_v = 1'b0, load, start, zero, ref_on, c0_out, irq;
    logic [15:0] c0_rl = 16'h0003, lo = 16'h0001, hi = 16'h0001;
    dtr_pkg::dtr_dac_bus_type wr = '0, bus;
    logic [7:0][11:0] levels, exp_lv;
    logic [11:0] d;
    int err_count = 0, total_checks = 0, seed = 76, n;
    always #50 i_clock = ~i_clock;
    dtr_timers u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_ref_enable(ref_en),
        .i_cnt0_run(c0_run), .i_cnt0_reload(c0_rl), .i_trig_run(tr_run),
        .i_trig_reload_lo(lo), .i_trig_reload_hi(hi), .i_irq_en_cnt0(en_c0),
        .i_irq_en_conv(en_cv), .i_irq_clear(clr), .i_wr_valid(wr_v), .i_wr(wr),
        .o_dac_bus(bus), .o_dac_load(load), .o_dac_start(start), .o_dac_zero(zero),
        .o_ref_on(ref_on), .o_cnt0_out(c0_out), .o_irq(irq));
    dtr_conv_model u_conv (.i_clock(i_clock), .i_bus(bus), .i_load(load),
        .i_start(start), .i_zero(zero), .o_level(levels));
    function automatic logic [11:0] exp_code(input logic on, input logic [11:0] v);
        return on ? v : dtr_pkg::CODE_ZERO;
    endfunction
    task wrap_up;
        $display("checks=%0d mismatches=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // sel 1 waits for a start pulse, sel 0 for a counter pin toggle
    task wait_ev(input bit sel, output int k);
        logic p;
        p = c0_out;
        k = 0;
        do begin
            @(negedge i_clock);
            k++;
            if (k > 2000) begin
                err_count++;
                wrap_up();
            end
        end while (sel ? start !== 1'b1 : c0_out === p);
    endtask
    task write_ch(input logic [2:0] a, input logic [11:0] v);
        wr.addr = a;
        wr.data = v;
        wr_v = 1'b1;
        @(negedge i_clock);
        wr_v = 1'b0;
        `CHK(load, 1'b1)
        `CHK(bus, {a, exp_code(ref_en, v)})
        @(negedge i_clock);
        `CHK(load, 1'b0)
    endtask
    initial begin
        repeat (12) @(negedge i_clock);
        `CHK({bus, load, start, zero, ref_on, c0_out, irq}, {15'h0000, 6'h0a})
        i_rst = 1'b0;
        write_ch(3'h5, dtr_pkg::CODE_MID);
        `CHK(zero, 1'b1)
        $display("test reset_standby done");
        ref_en = 1'b1;
        @(negedge i_clock);
        `CHK({ref_on, zero}, 2'h2)
        for (int i = 0; i < 8; i++) begin
            d = (i == 0) ? dtr_pkg::CODE_ZERO : (i == 1) ? dtr_pkg::CODE_FULL : 12'($random(seed));
            exp_lv[i] = d;
            write_ch(3'(i), d);
        end
        $display("test channel_write done");
        lo = 16'(1 + ($random(seed) & 3));
        hi = 16'(1 + ($random(seed) & 3));
        en_cv = 1'b1;
        tr_run = 1'b1;
        wait_ev(1'b1, n);
        wait_ev(1'b1, n);
        `CHK(n, 5 * lo * hi)
        `CHK(irq, 1'b1)
        @(negedge i_clock);
        `CHK(levels, exp_lv)
        tr_run = 1'b0;
        en_cv = 1'b0;
        $display("test trigger_chain done");
        c0_rl = 16'(2 + ($random(seed) & 7));
        en_c0 = 1'b1;
        c0_run = 1'b1;
        wait_ev(1'b0, n);
        wait_ev(1'b0, n);
        `CHK(n, c0_rl)
        if (c0_out === 1'b0) wait_ev(1'b0, n);
        clr = 1'b1;
        @(negedge i_clock);
        clr = 1'b0;
        `CHK(irq, 1'b0)
        wait_ev(1'b0, n);
        `CHK({c0_out, irq}, 2'h1)
        $display("test counter_irq done");
        ref_en = 1'b0;
        repeat (2) @(negedge i_clock);
        `CHK({ref_on, zero}, 2'h1)
        `CHK(levels, 96'h0)
        $display("test ref_off done");
        wrap_up();
    end
endmodule
